// File: rtl/sdc_channel.sv
// Serdes channel datapath: transmit FIFO, 8b/10b encoder, serializer, comma
// alignment, decoder and fixed-latency receive pipeline, plus the FIFO module.
// Assumes core_clk is the bit clock; the word rate is one cycle in twenty.
//
// Operation
// [RL1] Capture the 16-bit word each word clock; payload when enable high, error low.
// [RL2] Load-to-first-serial-bit latency lies within 34..38 bit times, fixed.
// [RL3] Split each word into two bytes, each with its own 8b/10b encoder.
// [RL4] Enable high, error low: encode both bytes as data characters.
// [RL5] Enable low, error high: send two K23.7 characters, ignore data.
// [RL6] Enable and error high: send two K30.7 characters.
// [RL7] Both low: send idle, K28.5 then D5.6 or D16.2.
// [RL8] Both idle characters go out within one word clock period.
// [RL9] K28.5 at negative disparity is 0011111010; first seven bits are the comma.
// [RL10] Track running disparity and pick forms that keep ones and zeros balanced.
// [RL11] Pattern-test high: load a 2^7-1 pseudorandom sequence into the serializer.
// [RL12] Pattern-test mode ignores the parallel bus and sends only the sequence.
// [RL13] Shift out 20 bits per word at twenty bit times per word.
// [RL14] Send the least significant bit, bit zero, first.
// [RL15] Align to two 10-bit boundaries, decode, output a 16-bit word.
// [RL16] Received word valid at rising recovered word clock; payload flagged valid, no error.
// [RL17] Receive latency fixed within 76..107 bit times.
// [RL18] First received bit of a word appears on output bit zero.
// [RL19] Lock only to a stream within 200 PPM of the local bit rate; the code has no rate check and locks on any comma at the aligned phase.
// [RL20] Word boundary is found by detecting the K28.5 comma.
// [RL21] Protocol side frames enable from first preamble word to last frame word.
// [RL22] Idle received: valid and error low, K28.5 and idle byte output.
// [RL23] Pseudorandom generator starts from a nonzero seed.
// [RL24] Idle second character chosen by running disparity to stay balanced.
`default_nettype none

module sdc_fifo #(
   parameter int unsigned WIDTH = 18,
   parameter int unsigned DEPTH = 32
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             reset,
   // Filling side.
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Draining side.
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign push       = in_valid && in_ready;
   assign pop        = out_valid && out_ready;
   assign out_valid  = (count != '0);
   assign out_data   = mem[rd_ptr];
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         in_ready <= 1'h0;
      end else begin
         wr_ptr   <= wr_ptr + AW'(push);
         rd_ptr   <= rd_ptr + AW'(pop);
         count    <= next_count;
         in_ready <= (next_count != (AW+1)'(DEPTH));
      end
   end
endmodule

module sdc_channel
   import sdc_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Transmit words from the protocol device.
   input  wire logic        tx_valid,
   input  wire logic [15:0] tx_parallel_word,
   input  wire logic        tx_enable,
   input  wire logic        tx_error_flag,
   output logic             tx_ready,
   output logic             tx_word_clock,
   // Test mode pin.
   input  wire logic        pattern_test_select,
   // Serial line.
   output logic             serial_out_pos,
   output logic             serial_out_neg,
   input  wire logic        serial_in_pos,
   input  wire logic        serial_in_neg,
   // Received words.
   output logic      [15:0] rx_parallel_word,
   output logic             rx_valid_or_signal_loss,
   output logic             rx_error_flag,
   output logic             rx_word_clock,
   output logic             rx_locked
);

   // Returns {running disparity after, code}; code bit 0 is sent first.
   function automatic logic [10:0] enc8b10b(input logic [7:0] b, input logic k,
                                            input logic rd);
      logic [5:0] s6;
      logic [3:0] s4;
      logic [9:0] code;
      logic       rd_mid;
      logic       k28;
      logic       alt;
      logic [4:0] x;
      x   = b[4:0];
      k28 = k && (x == SDC_X28);
      s6  = k28 ? SDC_K28_6B : SDC_ENC6[x];
      if (rd && (($countones(s6) != 3) || (s6 == SDC_D7_6B))) begin
         s6 = ~s6;
      end
      rd_mid = rd ^ ($countones(s6) != 3);
      alt = (b[7:5] == 3'h7) && (k
            || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
            || (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
      s4 = alt ? SDC_ALT7 : SDC_ENC4[b[7:5]];
      // Balanced K28 tails run opposite to data when rd_mid is low, so the comma stays unique.
      if (k28 && ($countones(s4) == 2)) begin
         s4 = rd_mid ? s4 : ~s4;
      end else if (rd_mid && (($countones(s4) != 2) || (s4 == SDC_Y3_4B))) begin
         s4 = ~s4;
      end
      for (int i = 0; i < 6; i++) begin
         code[i] = s6[5-i];
      end
      for (int i = 0; i < 4; i++) begin
         code[6+i] = s4[3-i];
      end
      return {rd_mid ^ ($countones(s4) != 2), code};
   endfunction

   // Returns {valid, control, byte}. Either disparity form is accepted.
   function automatic logic [9:0] dec8b10b(input logic [9:0] code);
      logic [9:0]  r;
      logic [10:0] e0;
      logic [10:0] e1;
      r = '0;
      for (int i = 0; i < 256; i++) begin
         e0 = enc8b10b(8'(i), 1'h0, 1'h0);
         e1 = enc8b10b(8'(i), 1'h0, 1'h1);
         if (e0[9:0] == code || e1[9:0] == code) begin
            r = {2'h2, 8'(i)};
         end
      end
      for (int i = 0; i < 3; i++) begin
         e0 = enc8b10b(SDC_KLIST[i], 1'h1, 1'h0);
         e1 = enc8b10b(SDC_KLIST[i], 1'h1, 1'h1);
         if (e0[9:0] == code || e1[9:0] == code) begin
            r = {2'h3, SDC_KLIST[i]};
         end
      end
      return r;
   endfunction

   // Advances the x^7+x^6+1 generator by one word; returns {state, bits}.
   function automatic logic [26:0] prbs20(input logic [6:0] s);
      logic [6:0]  st;
      logic [19:0] bits;
      st = s;
      for (int i = 0; i < 20; i++) begin
         bits[i] = st[6] ^ st[5];
         st      = {st[5:0], bits[i]};
      end
      return {st, bits};
   endfunction

   // Transmit side.
   logic          pat_s1;
   logic          pat_s2;
   logic [4:0]    tx_ph;
   logic          tx_tick;
   logic          fifo_valid;
   sdc_tx_item_t  fifo_item;
   sdc_tx_item_t  cap;
   logic          tx_rd;
   logic [19:0]   enc_word;
   logic [19:0]   shift;
   logic [6:0]    prbs;
   logic [26:0]   prbs_next;
   logic [7:0]    lo_byte;
   logic [7:0]    hi_byte;
   logic          lo_k;
   logic          hi_k;
   logic [10:0]   enc_lo;
   logic [10:0]   enc_hi;
   logic [19:0]   next_enc;

   assign tx_tick = (tx_ph == '0);

   sdc_fifo #(
      .WIDTH ($bits(sdc_tx_item_t)),
      .DEPTH (SDC_FIFO_DEPTH)
   ) u_tx_fifo (
      .clk       (core_clk),
      .reset     (reset),
      .in_valid  (tx_valid),
      .in_data   ({tx_enable, tx_error_flag, tx_parallel_word}),
      .in_ready  (tx_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_item),
      .out_ready (tx_tick)
   );

   // Byte selection by enable and error; low byte goes out first.
   assign lo_byte = (cap.en && !cap.err) ? cap.data[7:0]  :                  // [RL4] [RL3]
                    (cap.err ? (cap.en ? SDC_K30_7 : SDC_K23_7) : SDC_K28_5); // [RL5] [RL6] [RL7]
   assign hi_byte = (cap.en && !cap.err) ? cap.data[15:8] :
                    (cap.err ? (cap.en ? SDC_K30_7 : SDC_K23_7) :
                     (tx_rd ? SDC_D5_6 : SDC_D16_2));                          // [RL24]
   assign lo_k    = !(cap.en && !cap.err);
   assign hi_k    = cap.err;
   assign enc_lo  = enc8b10b(lo_byte, lo_k, tx_rd);                            // [RL9] [RL10]
   assign enc_hi  = enc8b10b(hi_byte, hi_k, enc_lo[10]);                       // [RL10]
   assign prbs_next = prbs20(prbs);
   assign next_enc  = pat_s2 ? prbs_next[19:0] : {enc_hi[9:0], enc_lo[9:0]};   // [RL11] [RL8]

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pat_s1 <= 1'h0;
         pat_s2 <= 1'h0;
         tx_ph  <= '0;
      end else begin
         pat_s1 <= pattern_test_select;
         pat_s2 <= pat_s1;
         tx_ph  <= (tx_ph == SDC_PH_LAST) ? '0 : tx_ph + 5'h01;
      end
   end

   // Words keep being drained in test mode so the bus is ignored, not stalled.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cap           <= '0;
         tx_word_clock <= 1'h0;
      end else begin
         if (tx_tick) begin
            cap <= fifo_valid ? fifo_item : '0;                                // [RL1] [RL12]
         end
         if (tx_tick) begin
            tx_word_clock <= 1'h1;
         end else if (tx_ph == SDC_PH_HALF) begin
            tx_word_clock <= 1'h0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         enc_word <= '0;
         tx_rd    <= 1'h0;
         prbs     <= SDC_PRBS_SEED;
      end else if (tx_ph == SDC_PH_LAST) begin
         enc_word <= next_enc;
         tx_rd    <= pat_s2 ? tx_rd : enc_hi[10];
         prbs     <= pat_s2 ? prbs_next[26:20] : SDC_PRBS_SEED;                // [RL23]
      end
   end

   // Loading at a fixed phase of the next word gives a constant 35-bit latency.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         shift          <= '0;
         serial_out_pos <= 1'h0;
         serial_out_neg <= 1'h1;
      end else if (tx_ph == SDC_TX_LOAD_PH) begin
         shift          <= {1'h0, enc_word[19:1]};                             // [RL2] [RL13]
         serial_out_pos <= enc_word[0];                                        // [RL14]
         serial_out_neg <= ~enc_word[0];
      end else begin
         shift          <= {1'h0, shift[19:1]};
         serial_out_pos <= shift[0];
         serial_out_neg <= ~shift[0];
      end
   end

   // Receive side.
   logic          sin_p1;
   logic          sin_p2;
   logic          sin_n1;
   logic          sin_n2;
   logic          rx_bit;
   logic [19:0]   hist;
   logic [4:0]    rx_ph;
   logic [4:0]    next_rx_ph;
   logic          comma;
   logic          aligned;
   logic          word_end;
   logic [9:0]    dec_lo;
   logic [9:0]    dec_hi;
   logic          bad;
   logic          rx_is_data;
   logic          rx_is_idle;
   logic          rx_is_cext;
   sdc_rx_word_t  rx_now;
   sdc_rx_word_t  rx_pipe [SDC_RX_STAGES];

   assign rx_bit   = sin_p2 & ~sin_n2;
   assign comma    = (hist[16:10] == SDC_COMMA_NEG) || (hist[16:10] == SDC_COMMA_POS); // [RL20]
   assign aligned  = (rx_ph == SDC_RX_ALIGN);
   assign word_end = (rx_ph == SDC_PH_LAST);
   // The comma search is frozen while locked so a bit error cannot slip the boundary.
   assign next_rx_ph = (comma && !rx_locked && !aligned) ? SDC_PH_HALF :     // [RL20]
                       (word_end ? '0 : rx_ph + 5'h01);

   // Earliest bit sits in hist[0], so it lands on output bit zero.
   assign dec_lo = dec8b10b(hist[9:0]);                                        // [RL15] [RL18]
   assign dec_hi = dec8b10b(hist[19:10]);
   assign bad    = !dec_lo[9] || !dec_hi[9];
   // Only idle and carrier extend clear valid; only idle and plain data clear error.
   // Error propagation, invalid codes and odd control mixes all fall through to both high.
   assign rx_is_data = !bad && !dec_lo[8] && !dec_hi[8];
   assign rx_is_idle = !bad && dec_lo[8] && (dec_lo[7:0] == SDC_K28_5) && !dec_hi[8]; // [RL22]
   assign rx_is_cext = !bad && dec_lo[8] && dec_hi[8]
                       && ({dec_hi[7:0], dec_lo[7:0]} == {SDC_K23_7, SDC_K23_7});
   assign rx_now     = {!(rx_is_idle || rx_is_cext), !(rx_is_idle || rx_is_data),     // [RL16]
                        dec_hi[7:0], dec_lo[7:0]};

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sin_p1 <= 1'h0;
         sin_p2 <= 1'h0;
         sin_n1 <= 1'h1;
         sin_n2 <= 1'h1;
         hist   <= '0;
         rx_ph  <= '0;
      end else begin
         sin_p1 <= serial_in_pos;
         sin_p2 <= sin_p1;
         sin_n1 <= serial_in_neg;
         sin_n2 <= sin_n1;
         hist   <= {rx_bit, hist[19:1]};
         rx_ph  <= next_rx_ph;
      end
   end

   // Sampling assumes the far end runs within tolerance of the local bit rate;
   // drift beyond it shows up as a decode error, which drops lock and reopens the search.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_locked <= 1'h0;
      end else if (comma && aligned) begin
         rx_locked <= 1'h1;                                                    // [RL19]
      end else if (word_end && bad) begin
         rx_locked <= 1'h0;                                                    // [RL19]
      end
   end

   // A fixed number of word stages pins the receive latency at 83 bit times.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < SDC_RX_STAGES; i++) begin
            rx_pipe[i] <= '0;
         end
         rx_parallel_word        <= '0;
         rx_valid_or_signal_loss <= 1'h0;
         rx_error_flag           <= 1'h0;
      end else if (word_end) begin
         rx_pipe[0] <= rx_now;
         for (int i = 1; i < SDC_RX_STAGES; i++) begin
            rx_pipe[i] <= rx_pipe[i-1];
         end
         rx_parallel_word        <= rx_pipe[SDC_RX_STAGES-1].data;             // [RL17]
         rx_valid_or_signal_loss <= rx_pipe[SDC_RX_STAGES-1].valid;
         rx_error_flag           <= rx_pipe[SDC_RX_STAGES-1].err;
      end
   end

   // Data changes on the falling word clock so it is stable at the rising edge.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_word_clock <= 1'h0;
      end else if (word_end) begin
         rx_word_clock <= 1'h0;
      end else if (rx_ph == SDC_RX_ALIGN) begin
         rx_word_clock <= 1'h1;                                                // [RL16]
      end
   end

endmodule

`default_nettype wire

// File: rtl/sdc_pkg.sv
// Shared constants and carrier types of the 8b/10b serdes channel datapath.
// Assumes one core clock that ticks once per serial bit time.
`default_nettype none

package sdc_pkg;

   // One core clock cycle is one serial bit time, so bit-time figures are cycle counts.
   localparam int unsigned SDC_WORD_BITS  = 20;
   localparam int unsigned SDC_TX_LAT_BT  = 35;
   localparam logic [4:0]  SDC_TX_LOAD_PH = 5'(SDC_TX_LAT_BT - SDC_WORD_BITS);
   localparam logic [4:0]  SDC_PH_LAST    = 5'(SDC_WORD_BITS - 1);
   localparam logic [4:0]  SDC_PH_HALF    = 5'h0A;
   localparam logic [4:0]  SDC_RX_ALIGN   = 5'h09;
   localparam int unsigned SDC_RX_STAGES  = 3;
   localparam int unsigned SDC_FIFO_DEPTH = 32;

   // Control and idle characters.
   localparam logic [7:0] SDC_K28_5 = 8'hBC;
   localparam logic [7:0] SDC_K23_7 = 8'hF7;
   localparam logic [7:0] SDC_K30_7 = 8'hFE;
   localparam logic [7:0] SDC_D5_6  = 8'hC5;
   localparam logic [7:0] SDC_D16_2 = 8'h50;
   localparam logic [0:2][7:0] SDC_KLIST = {SDC_K28_5, SDC_K23_7, SDC_K30_7};

   // Comma seen as code bits a..g with bit a in position 0.
   localparam logic [6:0] SDC_COMMA_NEG = 7'h7C;
   localparam logic [6:0] SDC_COMMA_POS = 7'h03;
   localparam logic [6:0] SDC_PRBS_SEED = 7'h7F;

   // Negative-disparity code tables, first transmitted bit as MSB.
   localparam logic [0:31][5:0] SDC_ENC6 = {
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [5:0]       SDC_D7_6B  = 6'h38;
   localparam logic [5:0]       SDC_K28_6B = 6'h0F;
   localparam logic [4:0]       SDC_X28    = 5'h1C;
   localparam logic [0:7][3:0]  SDC_ENC4   = {4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
   localparam logic [3:0]       SDC_Y3_4B  = 4'hC;
   localparam logic [3:0]       SDC_ALT7   = 4'h7;

   typedef struct packed {
      logic        en;
      logic        err;
      logic [15:0] data;
   } sdc_tx_item_t;

   typedef struct packed {
      logic        valid;
      logic        err;
      logic [15:0] data;
   } sdc_rx_word_t;

endpackage

`default_nettype wire

// File: tb/sdc_channel_checker.sv
// Port-level assertions for the serdes channel top.
// Assumes the bench loops the serial output straight back into the serial input.
`default_nettype none
module sdc_channel_checker
   import sdc_pkg::*;
(
   // Clock and reset.
   input wire logic        core_clk,
   input wire logic        reset,
   // Transmit side.
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic        tx_word_clock,
   input wire logic        pattern_test_select,
   // Serial line.
   input wire logic        serial_out_pos,
   input wire logic        serial_out_neg,
   // Receive side.
   input wire logic [15:0] rx_parallel_word,
   input wire logic        rx_valid_or_signal_loss,
   input wire logic        rx_error_flag,
   input wire logic        rx_word_clock,
   input wire logic        rx_locked
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   // Pattern mode may relock on a false comma, so latency and idle checks stop once it is used.
   logic            used_prbs;
   wire logic [7:0] hi_byte = rx_parallel_word[15:8];
   wire logic       idle_word = rx_locked && !rx_valid_or_signal_loss && !rx_error_flag;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) used_prbs <= 1'b0;
      else if (pattern_test_select) used_prbs <= 1'b1;
   end
   a_line_complement: assert property (serial_out_neg == !serial_out_pos)
      else $error("serial outputs not complementary");
   a_tx_word_period: assert property (
      $rose(tx_word_clock) |-> ##10 $fell(tx_word_clock) ##10 $rose(tx_word_clock))
      else $error("transmit word clock not twenty cycles");
   a_rx_word_period: assert property (
      $fell(rx_word_clock) && rx_locked |-> ##10 $rose(rx_word_clock) ##10 $fell(rx_word_clock))
      else $error("receive word clock not twenty cycles");
   a_rx_word_hold: assert property (
      rx_locked && !$stable({rx_parallel_word, rx_valid_or_signal_loss, rx_error_flag})
      |-> $fell(rx_word_clock))
      else $error("receive word changed away from its clock edge");
   a_loop_latency: assert property (
      $rose(tx_word_clock) && rx_locked && !used_prbs
      |-> ##118 ($fell(rx_word_clock) || !rx_locked || used_prbs))
      else $error("loop latency not 118 bit times");
   a_idle_decoded: assert property (
      $fell(rx_word_clock) && idle_word && !used_prbs
      |-> rx_parallel_word[7:0] == SDC_K28_5 && (hi_byte == SDC_D5_6 || hi_byte == SDC_D16_2))
      else $error("idle status with wrong idle bytes");
   a_ready_reset: assert property ($fell(reset) |=> tx_ready)
      else $error("transmit ready not raised after reset");
   a_ready_holds: assert property (tx_ready && !tx_valid |=> tx_ready)
      else $error("transmit ready dropped with no word offered");
   c_fifo_full: cover property (!tx_ready);
   c_err_prop: cover property ($fell(rx_word_clock) && rx_valid_or_signal_loss && rx_error_flag);
   c_carrier: cover property ($fell(rx_word_clock) && !rx_valid_or_signal_loss && rx_error_flag);
endmodule

bind sdc_channel sdc_channel_checker u_chk (
   .core_clk(core_clk), .reset(reset), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .tx_word_clock(tx_word_clock), .pattern_test_select(pattern_test_select),
   .serial_out_pos(serial_out_pos), .serial_out_neg(serial_out_neg),
   .rx_parallel_word(rx_parallel_word), .rx_valid_or_signal_loss(rx_valid_or_signal_loss),
   .rx_error_flag(rx_error_flag), .rx_word_clock(rx_word_clock), .rx_locked(rx_locked));
`default_nettype wire

// File: tb/sdc_mac_model.sv
// Protocol-side model that offers transmit words with their enable and error flags.
// Assumes a single caller process and the core clock of the channel.
`default_nettype none
module sdc_mac_model (
   // Clock.
   input  wire logic        core_clk,
   // Transmit word stream.
   input  wire logic        tx_ready,
   output var  logic        tx_valid,
   output var  logic [15:0] tx_parallel_word,
   output var  logic        tx_enable,
   output var  logic        tx_error_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   int n_refused = 0;
   initial begin
      tx_valid = 1'b0;
      tx_parallel_word = 16'h0000;
      tx_enable = 1'b0;
      tx_error_flag = 1'b0;
   end
   // Enable and error travel with the word and are held until it is taken.
   task automatic send(input logic en, input logic er, input logic [15:0] d, output bit ok);
      int i;
      @(negedge core_clk);
      tx_valid = 1'b1;
      tx_enable = en;
      tx_error_flag = er;
      tx_parallel_word = d;
      ok = 1'b0;
      for (i = 0; i < 400 && !ok; i++) begin
         @(posedge core_clk);
         if (tx_ready === 1'b1) ok = 1'b1;
         else n_refused++;
      end
   endtask
   // Inverted data after release, so a stale word is never mistaken for a held one.
   task automatic release_bus();
      @(negedge core_clk);
      tx_valid = 1'b0;
      tx_enable = 1'b0;
      tx_error_flag = 1'b0;
      tx_parallel_word = ~tx_parallel_word;
   endtask
endmodule
`default_nettype wire

// File: tb/sdc_channel_bench.sv
// Self-checking bench for the serdes channel, serial output looped back to its input.
// Assumes the protocol model offers the words and one core clock is one bit time.
`default_nettype none
module sdc_channel_bench
   import sdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [0:9] K28_5_NEG = 10'h0FA;
   logic         core_clk = 1'b0;
   logic         reset = 1'b1;
   logic         pattern_test_select = 1'b0;
   logic         mon_en = 1'b0;
   logic         rx_wc_q = 1'b0;
   logic         tx_valid, tx_enable, tx_error_flag, tx_ready, tx_word_clock;
   logic [15:0]  tx_parallel_word, rx_parallel_word;
   logic         ser_pos, ser_neg, rx_valid_or_signal_loss, rx_error_flag, rx_word_clock;
   logic         rx_locked;
   int           err_count = 0;
   int           n_compared = 0;
   sdc_rx_word_t exp_q[$];
   wire logic [17:0] rx_seen = {rx_valid_or_signal_loss, rx_error_flag, rx_parallel_word};
   always #50 core_clk = ~core_clk;
   sdc_mac_model u_mac (.core_clk(core_clk), .tx_ready(tx_ready), .tx_valid(tx_valid),
      .tx_parallel_word(tx_parallel_word), .tx_enable(tx_enable), .tx_error_flag(tx_error_flag));
   sdc_channel dut (
      .core_clk(core_clk), .reset(reset), .tx_valid(tx_valid),
      .tx_parallel_word(tx_parallel_word), .tx_enable(tx_enable),
      .tx_error_flag(tx_error_flag), .tx_ready(tx_ready), .tx_word_clock(tx_word_clock),
      .pattern_test_select(pattern_test_select), .serial_out_pos(ser_pos),
      .serial_out_neg(ser_neg), .serial_in_pos(ser_pos), .serial_in_neg(ser_neg),
      .rx_parallel_word(rx_parallel_word), .rx_valid_or_signal_loss(rx_valid_or_signal_loss),
      .rx_error_flag(rx_error_flag), .rx_word_clock(rx_word_clock), .rx_locked(rx_locked));
   task automatic check(input logic [17:0] seen, input logic [17:0] expd);
      n_compared++;
      if (seen !== expd) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, expd);
      end
   endtask
   task automatic close_out();
      if (err_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic give_up();
      err_count++;
      $display("[ERR] %0t wait ran out", $time);
      close_out();
   endtask
   task automatic wait_lock();
      int i;
      for (i = 0; i < 3000 && rx_locked !== 1'b1; i++) @(negedge core_clk);
      if (rx_locked !== 1'b1) give_up();
   endtask
   task automatic drain();
      int i;
      for (i = 0; i < 5000 && exp_q.size() != 0; i++) @(negedge core_clk);
      if (exp_q.size() != 0) give_up();
   endtask
   task automatic xmit(input logic en, input logic er, input logic [15:0] d);
      bit ok;
      u_mac.send(en, er, d, ok);
      if (!ok) give_up();
      if (en && !er) exp_q.push_back({2'b10, d});
      if (!en && er) exp_q.push_back({2'b01, SDC_K23_7, SDC_K23_7});
      if (en && er) exp_q.push_back({2'b11, SDC_K30_7, SDC_K30_7});
   endtask
   // Only locked words are judged, since a realign leaves garbage in the pipeline.
   always @(negedge core_clk) begin
      rx_wc_q <= rx_word_clock;
      if (mon_en && rx_locked === 1'b1 && rx_wc_q === 1'b1 && rx_word_clock === 1'b0) begin
         if (rx_seen[17:16] === 2'b00) begin
            check({10'h000, rx_seen[7:0]}, {10'h000, SDC_K28_5});
            check({17'h00000, rx_seen[15:8] inside {SDC_D5_6, SDC_D16_2}}, 18'h00001);
         end else if (exp_q.size() == 0) begin
            err_count++;
            $display("[ERR] %0t word with no pending note", $time);
         end else begin
            check(rx_seen, exp_q.pop_front());
         end
      end
   end
   initial begin
      int i;
      int ones;
      bit ok;
      logic [1:0] m;
      logic [6:0] hist;
      void'($urandom(32'h4f26));
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      reset = 1'b0;
      // An empty FIFO yields idle, so the first tx_tick capture puts K28.5 on the line.
      repeat (36) @(posedge core_clk);
      for (i = 0; i < 10; i++) begin
         @(negedge core_clk);
         check({17'h00000, ser_pos}, {17'h00000, K28_5_NEG[i]});
      end
      wait_lock();
      // Lock comes before the pre-lock words have left the word pipeline, so let them pass.
      repeat (80) @(negedge core_clk);
      mon_en = 1'b1;
      // Back-to-back words with every control code fill the FIFO until it refuses words.
      for (i = 0; i < 48; i++) begin
         m = (i < 4) ? 2'(i) : 2'($urandom);
         xmit(m[1], m[0], 16'($urandom));
      end
      u_mac.release_bus();
      check({17'h00000, u_mac.n_refused > 0}, 18'h00001);
      drain();
      mon_en = 1'b0;
      pattern_test_select = 1'b1;
      repeat (40) @(negedge core_clk);
      for (i = 0; i < 3; i++) u_mac.send(1'b1, 1'b0, 16'($urandom), ok);
      u_mac.release_bus();
      repeat (20) @(negedge core_clk);
      hist = 7'h00;
      ones = 0;
      for (i = 0; i < 300; i++) begin
         @(negedge core_clk);
         if (i >= 7) check({17'h00000, ser_pos}, {17'h00000, hist[6] ^ hist[5]});
         hist = {hist[5:0], ser_pos};
         ones += ser_pos;
      end
      check({17'h00000, ones != 0}, 18'h00001);
      pattern_test_select = 1'b0;
      repeat (300) @(negedge core_clk);
      wait_lock();
      repeat (200) @(negedge core_clk);
      mon_en = 1'b1;
      for (i = 0; i < 6; i++) xmit(1'b1, 1'b0, 16'($urandom));
      u_mac.release_bus();
      drain();
      close_out();
   end
endmodule
`default_nettype wire
